// [cacc_chan.sv]
`timescale 1ns/1ps
module cacc_chan (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] count_cur,
  input  wire logic [15:0] count_nxt,
  input  wire logic        count_tick,
  input  wire logic        wr_mode,
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  input  wire logic [7:0]  wr_data,
  input  wire logic        flag_clr,
  input  wire logic        io_in,
  output logic [7:0]       mode_reg,
  output logic [15:0]      cmp_reg,
  output logic             flag_reg,
  output logic             io_out_reg,
  output logic             io_oe_reg
);
  import cacc_pkg::*;

  logic       io_meta_reg;
  logic       io_sync_reg;
  logic       io_prev_reg;
  logic       io_level_reg;
  logic       stable;
  logic       rise;
  logic       fall;
  logic       hit;
  logic       cap_evt;
  logic       cmp_evt;
  cacc_mode_t mode;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_meta_reg <= 1'b0;
      io_sync_reg <= 1'b0;
      io_prev_reg <= 1'b0;
    end else begin
      io_meta_reg <= io_in;
      io_sync_reg <= io_meta_reg;
      io_prev_reg <= io_sync_reg;
    end
  end

  assign stable = (io_sync_reg == io_prev_reg);
  always_ff @(posedge aclk) begin
    if (!aresetn)
      io_level_reg <= 1'b0;
    else if (stable)
      io_level_reg <= io_sync_reg;
  end

  assign rise = stable & io_sync_reg & ~io_level_reg;
  assign fall = stable & ~io_sync_reg & io_level_reg;
  assign mode = cacc_decode(mode_reg);
  assign hit  = count_tick & (count_nxt == cmp_reg);

  assign cap_evt = (mode == mode_capture) &
                   ((rise & mode_reg[MB_RISE]) | (fall & mode_reg[MB_FALL]));
  assign cmp_evt = ((mode == mode_sw_timer) | (mode == mode_hso)) & hit;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      mode_reg <= MODE_RESET;
    else if (wr_mode)
      mode_reg <= wr_data;
    else if (wr_low)
      mode_reg[MB_CMP_EN] <= 1'b0;
    else if (wr_high)
      mode_reg[MB_CMP_EN] <= 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      cmp_reg <= CMP_RESET;
    else if (cap_evt)
      cmp_reg <= count_cur;
    else if (wr_low)
      cmp_reg[7:0] <= wr_data;
    else if (wr_high)
      cmp_reg[15:8] <= wr_data;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      flag_reg <= 1'b0;
    else if (cap_evt | cmp_evt)
      flag_reg <= 1'b1;
    else if (flag_clr)
      flag_reg <= 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_oe_reg  <= 1'b0;
      io_out_reg <= 1'b1;
    end else begin
      io_oe_reg <= (mode == mode_hso);
      if ((mode == mode_hso) & ~io_oe_reg)
        io_out_reg <= 1'b1;
      else if (cmp_evt & (mode == mode_hso))
        io_out_reg <= ~io_out_reg;
    end
  end

endmodule : cacc_chan

// [cacc_monitor.sv]
`timescale 1ns/1ps
module cacc_monitor import cacc_pkg::*; #(
  parameter int unsigned NMOD = cacc_pkg::NUM_MODULES
) (
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic [cacc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_awready,
  input wire logic                        s_axi_wvalid,
  input wire logic [1:0]                  s_axi_bresp,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_bready,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic [31:0]                 s_axi_rdata,
  input wire logic                        s_axi_rvalid,
  input wire logic                        s_axi_rready,
  input wire logic                        count_irq_req,
  input wire logic [NMOD-1:0]             module_irq_req,
  input wire logic [NMOD-1:0]             module_io_line_out,
  input wire logic [NMOD-1:0]             module_io_line_oe
);
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic wr_take;
  assign wr_take = s_axi_awvalid & s_axi_wvalid & s_axi_awready;
  wr_resp_a : assert property (wr_take |=> s_axi_bvalid)
    else $error("write response missing");
  rd_resp_a : assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  rd_ready_a : assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read ready wrong");
  b_hold_a : assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  r_hold_a : assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  ovf_hold_a : assert property (
    $fell(count_irq_req) |-> $past(wr_take) && $past(s_axi_awaddr) == ADDR_MODE)
    else $error("overflow request fell without write");
  flag_hold_a : assert property (
    |($past(module_irq_req) & ~module_irq_req) |-> $past(wr_take))
    else $error("module request fell without write");
  hso_init_a : assert property (
    !(|(module_io_line_oe & ~$past(module_io_line_oe) & ~module_io_line_out)))
    else $error("toggle output not one on entry");
endmodule : cacc_monitor

bind cacc_top cacc_monitor #(.NMOD(NMOD)) cacc_monitor_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .count_irq_req(count_irq_req),
  .module_irq_req(module_irq_req), .module_io_line_out(module_io_line_out),
  .module_io_line_oe(module_io_line_oe));

// [cacc_partner.sv]
`timescale 1ns/1ps
module cacc_partner (
  input  wire logic       aclk,
  output logic            timer0_ovf,
  output logic            ext_osc_in,
  output logic            ext_count_input,
  output logic [5:0]      io_drive
);
  logic [7:0] phase;
  initial begin
    phase = 8'h00;
    timer0_ovf = 1'b0;
    ext_osc_in = 1'b0;
    ext_count_input = 1'b1;
    io_drive = 6'h00;
  end
  always @(posedge aclk) begin
    phase           <= phase + 8'h01;
    timer0_ovf      <= (phase[2:0] == 3'h7);
    ext_osc_in      <= phase[1];
    ext_count_input <= phase[2];
  end
  task automatic set_io(input int n, input logic v);
    io_drive[n] <= v;
    repeat (6) @(posedge aclk);
  endtask : set_io
endmodule : cacc_partner

// [cacc_pkg.sv]
package cacc_pkg;

  localparam int unsigned NUM_MODULES = 6;
  localparam int unsigned ADDR_W      = 8;

  // byte addresses of the array registers
  localparam logic [7:0] ADDR_MODE    = 8'h00;
  localparam logic [7:0] ADDR_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO  = 8'h08;
  localparam logic [7:0] ADDR_CNT_HI  = 8'h0C;
  // module n occupies 16 bytes at (n + MOD_SLOT_BASE) * 16
  localparam logic [3:0] MOD_SLOT_BASE = 4'h2;
  localparam logic [3:0] OFS_MOD_MODE  = 4'h0;
  localparam logic [3:0] OFS_CMP_LO    = 4'h4;
  localparam logic [3:0] OFS_CMP_HI    = 4'h8;

  // array_mode_reg fields
  localparam int unsigned MD_OVF_IE  = 0;
  localparam int unsigned MD_TB_LSB  = 1;
  localparam int unsigned MD_IDLE    = 7;
  localparam int unsigned MD_OVF     = 8;

  // module_mode_reg fields
  localparam int unsigned MB_WIDE    = 7;
  localparam int unsigned MB_CMP_EN  = 6;
  localparam int unsigned MB_RISE    = 5;
  localparam int unsigned MB_FALL    = 4;
  localparam int unsigned MB_HIT     = 3;
  localparam int unsigned MB_FLIP    = 2;
  localparam int unsigned MB_PULSE   = 1;
  localparam int unsigned MB_IRQ_EN  = 0;

  // reset values
  localparam logic [2:0]  TB_RESET    = 3'h0;
  localparam logic [7:0]  MODE_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] CMP_RESET   = 16'h0000;

  // timebase codes
  localparam logic [2:0] TB_DIV12  = 3'h0;
  localparam logic [2:0] TB_DIV4   = 3'h1;
  localparam logic [2:0] TB_T0OVF  = 3'h2;
  localparam logic [2:0] TB_EXTCNT = 3'h3;
  localparam logic [2:0] TB_SYSCLK = 3'h4;
  localparam logic [2:0] TB_OSC8   = 3'h5;
  localparam logic [2:0] TB_RSV6   = 3'h6;
  localparam logic [2:0] TB_RSV7   = 3'h7;

  // divider terminal counts
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [1:0] DIV4_LAST  = 2'h3;
  localparam logic [2:0] OSC8_LAST  = 3'h7;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    mode_off, mode_capture, mode_sw_timer, mode_hso,
    mode_freq, mode_pwm8, mode_pwm16
  } cacc_mode_t;

  function automatic cacc_mode_t cacc_decode(input logic [7:0] m);
    cacc_mode_t r;
    r = mode_off;
    if ((m[MB_RISE] | m[MB_FALL]) & ~m[MB_HIT] & ~m[MB_FLIP] & ~m[MB_PULSE])
      r = mode_capture;
    else if (m[MB_CMP_EN] & ~m[MB_RISE] & ~m[MB_FALL]) begin
      if (m[MB_HIT] & ~m[MB_FLIP] & ~m[MB_PULSE])
        r = mode_sw_timer;
      else if (m[MB_HIT] & m[MB_FLIP] & ~m[MB_PULSE])
        r = mode_hso;
      else if (~m[MB_HIT] & m[MB_FLIP] & m[MB_PULSE])
        r = mode_freq;
      else if (~m[MB_HIT] & ~m[MB_FLIP] & m[MB_PULSE] & ~m[MB_IRQ_EN])
        r = m[MB_WIDE] ? mode_pwm16 : mode_pwm8;
    end
    return r;
  endfunction : cacc_decode

endpackage : cacc_pkg

// [cacc_tb_top.sv]
`timescale 1ns/1ps
module cacc_tb_top;
  import cacc_pkg::*;
  localparam logic [31:0] STOP = {28'h0, TB_RSV6, 1'b0};
  logic        aclk, aresetn, cpu_idle, timer0_ovf, ext_osc_in, ext_count_input;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat, cnt;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, count_irq_req, ok;
  logic [5:0]  io_line, io_drive, io_out, io_oe, mod_irq;
  int          err_count, tests_run;
  always #12.5 aclk = ~aclk;
  assign io_line = (io_oe & io_out) | (~io_oe & io_drive);
  cacc_top cacc_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cpu_idle(cpu_idle),
    .timer0_ovf(timer0_ovf), .ext_osc_in(ext_osc_in),
    .ext_count_input(ext_count_input), .module_io_line_in(io_line),
    .module_io_line_out(io_out), .module_io_line_oe(io_oe),
    .count_irq_req(count_irq_req), .module_irq_req(mod_irq));
  cacc_partner cacc_partner_inst (.aclk(aclk), .timer0_ovf(timer0_ovf),
    .ext_osc_in(ext_osc_in), .ext_count_input(ext_count_input),
    .io_drive(io_drive));

  task automatic stop_test();
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wait_on(input int w);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while ((w == 0 ? s_axi_awready & s_axi_wready :
                w == 1 ? s_axi_bvalid :
                w == 2 ? s_axi_arready : s_axi_rvalid) !== 1'b1 && n < 60);
    if (n >= 60) begin
      err_count++;
      stop_test();
    end
  endtask : wait_on

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    wait_on(0);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    wait_on(1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    wait_on(2);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    wait_on(3);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, 4'h1);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    axi_rd(a);
    chk(nm, e, rdat);
  endtask : rd_chk

  function automatic logic [7:0] ma(input logic [3:0] n, input logic [3:0] o);
    return {n + MOD_SLOT_BASE, o};
  endfunction : ma

  task automatic set_cnt(input logic [15:0] v);
    wr(ADDR_MODE, STOP);
    wr(ADDR_CNT_LO, {24'h0, v[7:0]});
    wr(ADDR_CNT_HI, {24'h0, v[15:8]});
  endtask : set_cnt

  task automatic rd_cnt();
    axi_rd(ADDR_CNT_LO);
    cnt = rdat;
    axi_rd(ADDR_CNT_HI);
    cnt = {16'h0, rdat[7:0], cnt[7:0]};
  endtask : rd_cnt

  task automatic t_basic();
    rd_chk(ADDR_MODE, {28'h0, TB_RESET, 1'b0}, "mode reset");
    rd_chk(ma(1, OFS_MOD_MODE), {24'h0, MODE_RESET}, "module reset");
    axi_wr(8'hF0, 32'hFF, 4'hF);
    chk("wr resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    rd_chk(8'hF0, 32'h0, "unmapped data");
    chk("rd resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
  endtask : t_basic

  task automatic t_timebase();
    int per[8] = '{12, 4, 8, 8, 1, 32, 0, 0};
    int e;
    cpu_idle <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      set_cnt(16'h0000);
      wr(ADDR_MODE, {28'h0, 3'(c), 1'b0});
      repeat (96) @(posedge aclk);
      wr(ADDR_MODE, STOP);
      rd_cnt();
      e = per[c] == 0 ? 0 : 100 / per[c];
      ok = (cnt + 3 >= e) && (cnt <= e + (per[c] == 0 ? 0 : 3));
      chk("count rate", 32'h1, {31'h0, ok});
    end
    set_cnt(16'h0000);
    wr(ADDR_MODE, 32'h88);
    repeat (20) @(posedge aclk);
    wr(ADDR_MODE, STOP);
    rd_cnt();
    chk("idle count", 32'h0, cnt);
    cpu_idle <= 1'b0;
  endtask : t_timebase

  task automatic t_counter();
    set_cnt(16'h12FF);
    rd_chk(ADDR_CNT_LO, 32'hFF, "count low");
    wr(ADDR_CNT_HI, 32'h34);
    rd_chk(ADDR_CNT_HI, 32'h12, "snapshot");
    set_cnt(16'hFFF0);
    wr(ADDR_MODE, {28'h0, TB_SYSCLK, 1'b1});
    repeat (30) @(posedge aclk);
    wr(ADDR_MODE, STOP | 32'h1);
    rd_chk(ADDR_MODE, 32'h10D, "ovf set");
    chk("ovf irq", 32'h1, {31'h0, count_irq_req});
    wr(ADDR_MODE, STOP);
    chk("ovf masked", 32'h0, {31'h0, count_irq_req});
    rd_chk(ADDR_MODE, 32'h10C, "ovf kept");
    axi_wr(ADDR_MODE, STOP, 4'h3);
    rd_chk(ADDR_MODE, STOP, "ovf clear");
  endtask : t_counter

  task automatic t_capture();
    set_cnt(16'h1234);
    wr(ma(0, OFS_MOD_MODE), 32'h21);
    cacc_partner_inst.set_io(0, 1'b1);
    rd_chk(ma(0, OFS_CMP_LO), 32'h34, "cap low");
    rd_chk(ma(0, OFS_CMP_HI), 32'h12, "cap high");
    chk("cap irq", 32'h1, {26'h0, mod_irq});
    set_cnt(16'h5678);
    cacc_partner_inst.set_io(0, 1'b0);
    rd_chk(ma(0, OFS_CMP_LO), 32'h34, "no fall cap");
    wr(ma(0, OFS_MOD_MODE), 32'h20);
    chk("irq masked", 32'h0, {26'h0, mod_irq});
    wr(ADDR_CTRL, 32'h3F);
    rd_chk(ADDR_CTRL, 32'h01, "flag kept");
    wr(ADDR_CTRL, 32'h00);
    rd_chk(ADDR_CTRL, 32'h00, "flag clear");
    wr(ma(0, OFS_MOD_MODE), 32'h10);
    cacc_partner_inst.set_io(0, 1'b1);
    cacc_partner_inst.set_io(0, 1'b0);
    rd_chk(ma(0, OFS_CMP_LO), 32'h78, "fall cap");
    set_cnt(16'h9ABC);
    wr(ma(0, OFS_MOD_MODE), 32'h30);
    cacc_partner_inst.set_io(0, 1'b1);
    rd_chk(ma(0, OFS_CMP_LO), 32'hBC, "both cap");
  endtask : t_capture

  task automatic t_hso();
    set_cnt(16'h0000);
    wr(ma(1, OFS_MOD_MODE), 32'h4D);
    chk("hso entry", 32'h3, {30'h0, io_oe[1], io_out[1]});
    wr(ma(1, OFS_CMP_LO), 32'h10);
    rd_chk(ma(1, OFS_MOD_MODE), 32'h0D, "cmp off");
    wr(ma(1, OFS_CMP_HI), 32'h00);
    rd_chk(ma(1, OFS_MOD_MODE), 32'h4D, "cmp on");
    wr(ma(2, OFS_MOD_MODE), 32'h09);
    wr(ma(2, OFS_CMP_LO), 32'h18);
    wr(ma(2, OFS_CMP_HI), 32'h00);
    wr(ma(3, OFS_CMP_LO), 32'h18);
    wr(ma(3, OFS_MOD_MODE), 32'h46);
    wr(ADDR_MODE, {28'h0, TB_SYSCLK, 1'b0});
    repeat (4) rd_cnt();
    wr(ADDR_MODE, STOP);
    chk("hso flip", 32'h2, {30'h0, io_oe[1], io_out[1]});
    chk("no out", 32'h0, {30'h0, io_oe[3], io_oe[2]});
    rd_chk(ADDR_CTRL, 32'h07, "match flag");
    chk("match irq", 32'h6, {26'h0, mod_irq});
    rd_cnt();
    chk("run count", 32'h1, {31'h0, cnt >= 32 && cnt <= 40});
  endtask : t_hso

  initial begin
    err_count = 0;
    tests_run = 0;
    aclk = 1'b0;
    aresetn = 1'b0;
    cpu_idle = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_basic();
    t_timebase();
    t_counter();
    t_capture();
    t_hso();
    stop_test();
  end
endmodule : cacc_tb_top

// [cacc_top.sv]
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module cacc_top #(
  parameter int unsigned NMOD = cacc_pkg::NUM_MODULES
) (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [cacc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [cacc_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         cpu_idle,
  input  wire logic                         timer0_ovf,
  input  wire logic                         ext_osc_in,
  input  wire logic                         ext_count_input,
  input  wire logic [NMOD-1:0]              module_io_line_in,
  output logic [NMOD-1:0]                   module_io_line_out,
  output logic [NMOD-1:0]                   module_io_line_oe,
  output logic                              count_irq_req,
  output logic [NMOD-1:0]                   module_irq_req
);
  import cacc_pkg::*;

  logic [2:0]  timebase_select_reg;
  logic        overflow_irq_enable_reg;
  logic        idle_suspend_reg;
  logic        count_overflow_flag_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [7:0]  hi_snap_reg;
  logic [3:0]  pre12_reg;
  logic [1:0]  pre4_reg;
  logic [2:0]  osc_div_reg;
  logic        eci_meta_reg;
  logic        eci_sync_reg;
  logic        eci_prev_reg;
  logic        osc_meta_reg;
  logic        osc_sync_reg;
  logic        osc_prev_reg;
  logic        eci_fall;
  logic        osc_rise;
  logic        src_tick;
  logic        cnt_tick;
  logic        cnt_wr_lo;
  logic        cnt_wr_hi;

  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        wr_fire;
  logic        rd_fire;
  logic        wr_en;
  logic [7:0]  wbyte;
  logic [3:0]  wslot;
  logic [3:0]  rslot;
  logic [3:0]  widx;
  logic [3:0]  ridx;
  logic        wr_mod;
  logic        rd_mod;
  logic        wr_ok;
  logic        rd_ok;
  logic [31:0] rd_word;

  logic [7:0]  mod_mode  [NMOD];
  logic [15:0] mod_cmp   [NMOD];
  logic [NMOD-1:0] mod_flag;

  // ---------------- bus slave ----------------
  assign wr_fire       = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign rd_fire       = s_axi_arvalid & ~rvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  assign wr_en = wr_fire & s_axi_wstrb[0];
  assign wbyte = s_axi_wdata[7:0];
  assign wslot = s_axi_awaddr[7:4];
  assign rslot = s_axi_araddr[7:4];
  assign widx  = wslot - MOD_SLOT_BASE;
  assign ridx  = rslot - MOD_SLOT_BASE;
  assign wr_mod = (wslot >= MOD_SLOT_BASE) &
                  (widx < 4'(NMOD)) & (s_axi_awaddr[1:0] == 2'h0) &
                  ((s_axi_awaddr[3:0] == OFS_MOD_MODE) |
                   (s_axi_awaddr[3:0] == OFS_CMP_LO) |
                   (s_axi_awaddr[3:0] == OFS_CMP_HI));
  assign rd_mod = (rslot >= MOD_SLOT_BASE) &
                  (ridx < 4'(NMOD)) & (s_axi_araddr[1:0] == 2'h0) &
                  ((s_axi_araddr[3:0] == OFS_MOD_MODE) |
                   (s_axi_araddr[3:0] == OFS_CMP_LO) |
                   (s_axi_araddr[3:0] == OFS_CMP_HI));
  assign wr_ok = wr_mod | (s_axi_awaddr == ADDR_MODE) |
                 (s_axi_awaddr == ADDR_CTRL) |
                 (s_axi_awaddr == ADDR_CNT_LO) |
                 (s_axi_awaddr == ADDR_CNT_HI);
  assign rd_ok = rd_mod | (s_axi_araddr == ADDR_MODE) |
                 (s_axi_araddr == ADDR_CTRL) |
                 (s_axi_araddr == ADDR_CNT_LO) |
                 (s_axi_araddr == ADDR_CNT_HI);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_mod) begin
      if (s_axi_araddr[3:0] == OFS_MOD_MODE)
        rd_word[7:0] = mod_mode[ridx[2:0]];
      else if (s_axi_araddr[3:0] == OFS_CMP_LO)
        rd_word[7:0] = mod_cmp[ridx[2:0]][7:0];
      else
        rd_word[7:0] = mod_cmp[ridx[2:0]][15:8];
    end else if (s_axi_araddr == ADDR_MODE) begin
      rd_word[MD_OVF_IE]             = overflow_irq_enable_reg;
      rd_word[MD_TB_LSB+2:MD_TB_LSB] = timebase_select_reg;
      rd_word[MD_IDLE]               = idle_suspend_reg;
      rd_word[MD_OVF]                = count_overflow_flag_reg;
    end else if (s_axi_araddr == ADDR_CTRL) begin
      rd_word[NMOD-1:0] = mod_flag;
    end else if (s_axi_araddr == ADDR_CNT_LO) begin
      rd_word[7:0] = count_reg[7:0];
    end else if (s_axi_araddr == ADDR_CNT_HI) begin
      rd_word[7:0] = hi_snap_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      hi_snap_reg <= 8'h00;
    else if (rd_fire & (s_axi_araddr == ADDR_CNT_LO))
      hi_snap_reg <= count_reg[15:8];
  end

  // ---------------- array mode register ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_irq_enable_reg <= 1'b0;
      timebase_select_reg     <= TB_RESET;
      idle_suspend_reg        <= 1'b0;
    end else if (wr_en & (s_axi_awaddr == ADDR_MODE)) begin
      overflow_irq_enable_reg <= wbyte[MD_OVF_IE];
      timebase_select_reg     <= wbyte[MD_TB_LSB+2:MD_TB_LSB];
      idle_suspend_reg        <= wbyte[MD_IDLE];
    end
  end

  // ---------------- timebase sources ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eci_meta_reg <= 1'b1;
      eci_sync_reg <= 1'b1;
      eci_prev_reg <= 1'b1;
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end else begin
      eci_meta_reg <= ext_count_input;
      eci_sync_reg <= eci_meta_reg;
      eci_prev_reg <= eci_sync_reg;
      osc_meta_reg <= ext_osc_in;
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
    end
  end

  assign eci_fall = eci_prev_reg & ~eci_sync_reg;
  assign osc_rise = ~osc_prev_reg & osc_sync_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre12_reg   <= 4'h0;
      pre4_reg    <= 2'h0;
      osc_div_reg <= 3'h0;
    end else begin
      pre12_reg <= (pre12_reg == DIV12_LAST) ? 4'h0 : pre12_reg + 4'h1;
      pre4_reg  <= pre4_reg + 2'h1;
      if (osc_rise)
        osc_div_reg <= osc_div_reg + 3'h1;
    end
  end

  always_comb begin
    case (timebase_select_reg)
      TB_DIV12:  src_tick = (pre12_reg == DIV12_LAST);
      TB_DIV4:   src_tick = (pre4_reg == DIV4_LAST);
      TB_T0OVF:  src_tick = timer0_ovf;
      TB_EXTCNT: src_tick = eci_fall;
      TB_SYSCLK: src_tick = 1'b1;
      TB_OSC8:   src_tick = osc_rise & (osc_div_reg == OSC8_LAST);
      TB_RSV6,
      TB_RSV7:   src_tick = 1'b0;
      default:   src_tick = 1'b0;
    endcase
  end

  // ---------------- counter ----------------
  assign cnt_wr_lo = wr_en & (s_axi_awaddr == ADDR_CNT_LO);
  assign cnt_wr_hi = wr_en & (s_axi_awaddr == ADDR_CNT_HI);
  assign cnt_tick   = src_tick & ~(idle_suspend_reg & cpu_idle) &
                      ~cnt_wr_lo & ~cnt_wr_hi;
  assign count_next = count_reg + 16'h0001;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      count_reg <= COUNT_RESET;
    else if (cnt_wr_lo)
      count_reg[7:0] <= wbyte;
    else if (cnt_wr_hi)
      count_reg[15:8] <= wbyte;
    else if (cnt_tick)
      count_reg <= count_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      count_overflow_flag_reg <= 1'b0;
    else if (cnt_tick & (count_reg == COUNT_MAX))
      count_overflow_flag_reg <= 1'b1;
    else if (wr_fire & s_axi_wstrb[1] & (s_axi_awaddr == ADDR_MODE) &
             ~s_axi_wdata[MD_OVF])
      count_overflow_flag_reg <= 1'b0;
  end

  assign count_irq_req = count_overflow_flag_reg & overflow_irq_enable_reg;

  // ---------------- capture/compare modules ----------------
  // six modules share counter
  for (genvar n = 0; n < NMOD; n++) begin : g_mod
    logic sel;
    assign sel = wr_en & wr_mod & (widx == 4'(n));
    cacc_chan u_chan (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .count_cur  (count_reg),
      .count_nxt  (count_next),
      .count_tick (cnt_tick),
      .wr_mode    (sel & (s_axi_awaddr[3:0] == OFS_MOD_MODE)),
      .wr_low     (sel & (s_axi_awaddr[3:0] == OFS_CMP_LO)),
      .wr_high    (sel & (s_axi_awaddr[3:0] == OFS_CMP_HI)),
      .wr_data    (wbyte),
      .flag_clr   (wr_en & (s_axi_awaddr == ADDR_CTRL) & ~wbyte[n]),
      .io_in      (module_io_line_in[n]),
      .mode_reg   (mod_mode[n]),
      .cmp_reg    (mod_cmp[n]),
      .flag_reg   (mod_flag[n]),
      .io_out_reg (module_io_line_out[n]),
      .io_oe_reg  (module_io_line_oe[n])
    );
    assign module_irq_req[n] = mod_flag[n] & mod_mode[n][MB_IRQ_EN];
  end

endmodule : cacc_top
